//--- rtl/ppfr_pkg.sv
// constants shared by the power-on fault and channel re-map register logic
package ppfr_pkg;
    // command codes of the management bus
    localparam logic [7:0] PPFR_CMD_FAULT_RO = 8'h24;   // non-destructive fault view
    localparam logic [7:0] PPFR_CMD_FAULT_COR = 8'h25;  // clear-on-read fault view
    localparam logic [7:0] PPFR_CMD_REMAP = 8'h26;      // channel re-map byte
    localparam logic [7:0] PPFR_CMD_SOFT_RESET = 8'h1a; // software reset command
    // widths and reset values
    localparam int PPFR_NUM_CH = 4;                      // channels in one group
    localparam int PPFR_CAUSE_W = 2;                     // bits per channel field
    localparam int PPFR_BYTE_W = 8;                      // data byte width
    localparam logic [7:0] PPFR_FAULT_RESET = 8'h00;     // fault byte after reset
    localparam logic [7:0] PPFR_REMAP_DEFAULT = 8'he4;   // identity mapping
    localparam logic [7:0] PPFR_UNMAPPED_READ = 8'h00;   // answer to unknown codes
    // fault cause encoding
    typedef logic [1:0] ppfr_cause_t;
    localparam ppfr_cause_t PPFR_CAUSE_NONE = 2'h0;      // no fault
    localparam ppfr_cause_t PPFR_CAUSE_INVALID_DET = 2'h1; // invalid detection
    localparam ppfr_cause_t PPFR_CAUSE_CLASS_ERR = 2'h2; // classification error
    localparam ppfr_cause_t PPFR_CAUSE_NO_POWER = 2'h3;  // insufficient power
endpackage : ppfr_pkg

//--- rtl/ppfr_fault_slot.sv
// one channel's two-bit turn-on failure cause cell
module ppfr_fault_slot (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // events
    input wire logic record_fault,
    input wire ppfr_pkg::ppfr_cause_t record_cause,
    input wire logic clear_fault,
    // stored cause
    output ppfr_pkg::ppfr_cause_t turn_on_failure_cause
);
    import ppfr_pkg::*;

    // record wins over any clear landing in the same cycle, so no failure is lost
    always_ff @(posedge clk) begin
        if (rst) begin
            turn_on_failure_cause <= PPFR_CAUSE_NONE;
        end else if (ce) begin
            if (record_fault) begin
                turn_on_failure_cause <= record_cause;
            end else if (clear_fault) begin
                turn_on_failure_cause <= PPFR_CAUSE_NONE;
            end
        end
    end
endmodule : ppfr_fault_slot

//--- rtl/ppfr_top.sv
// power-on fault status and channel re-map registers for one four-channel group
// Summary of operation
// - command 24h reads faults without clearing
// - command 25h reads faults then clears them
// - two-bit failure cause per channel stored
// - channel turn-off clears its cause
// - codes none, detection, class, power
// - record cause when classification enable clear
// - power denial reports insufficient power code
// - command 26h reads and writes re-map
// - power-on loads identity re-map e4h
// - re-map stays inside four-channel group
// - re-map write ignored unless group off
// - logical channel four in top pair
// - codes 00..11 pick physical one..four
// - duplicate physical codes discard the write
// - re-map survives pin and software reset
module ppfr_top (
    // clock, resets, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    input wire logic ce,
    // command port from the bus slave
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    // read answer
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    // channel engine status
    input wire logic [3:0] channel_power_up_command,
    input wire logic [7:0] fault_cause_in,
    input wire logic [3:0] classification_enable_bit,
    input wire logic [3:0] power_denied,
    input wire logic [3:0] channel_turned_off,
    input wire logic [3:0] channel_is_off,
    // register contents toward the channel logic
    output logic [7:0] channel_remap,
    output logic [7:0] fault_status
);
    import ppfr_pkg::*;

    logic [7:0] stored_status; // shared storage for both fault views
    logic rd_strobe; // accepted read command
    logic wr_strobe; // accepted write command
    logic remap_dup; // write data repeats a physical code
    logic remap_ok; // write may be taken
    logic soft_reset; // software reset command seen
    logic clear_on_read; // 25h read in progress

    // duplicate check over every pair of two-bit fields
    function automatic logic has_dup(input logic [7:0] map);
        logic dup;
        dup = 1'b0;
        for (int i = 0; i < PPFR_NUM_CH; i++) begin
            for (int j = i + 1; j < PPFR_NUM_CH; j++) begin
                if (map[i*PPFR_CAUSE_W +: PPFR_CAUSE_W] == map[j*PPFR_CAUSE_W +: PPFR_CAUSE_W]) begin
                    dup = 1'b1;
                end
            end
        end
        return dup;
    endfunction : has_dup

    // command decode
    assign rd_strobe = ce && cmd_valid && !cmd_write;
    assign wr_strobe = ce && cmd_valid && cmd_write;
    assign soft_reset = wr_strobe && (cmd_code == PPFR_CMD_SOFT_RESET);
    assign clear_on_read = rd_strobe && (cmd_code == PPFR_CMD_FAULT_COR);
    assign remap_dup = has_dup(cmd_wdata);
    // all four must be off; codes are only 2 bits so the group cannot be left
    assign remap_ok = (&channel_is_off) && !remap_dup;

    // one cell per channel; both read views address these same flops
    for (genvar g = 0; g < PPFR_NUM_CH; g++) begin : g_slot
        ppfr_cause_t cause_pick; // cause to store on a failed turn-on
        logic record; // failed turn-on with classification enable clear
        // denial by the power-allocation setup overrides the engine's cause
        assign cause_pick = power_denied[g] ? PPFR_CAUSE_NO_POWER
                          : fault_cause_in[g*PPFR_CAUSE_W +: PPFR_CAUSE_W];
        assign record = channel_power_up_command[g] && !classification_enable_bit[g];
        ppfr_fault_slot u_slot (
            .clk(clk),
            .rst(rst || soft_reset),
            .ce(ce),
            .record_fault(record),
            .record_cause(cause_pick),
            .clear_fault(channel_turned_off[g] || clear_on_read),
            .turn_on_failure_cause(stored_status[g*PPFR_CAUSE_W +: PPFR_CAUSE_W])
        );
    end

    // status mirror toward the pins, one cycle behind the cells
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_status <= PPFR_FAULT_RESET;
        end else if (ce) begin
            fault_status <= stored_status;
        end
    end

    // re-map register: only power-on restores it, pin and soft reset leave it
    always_ff @(posedge clk) begin
        if (por) begin
            channel_remap <= PPFR_REMAP_DEFAULT;
        end else if (wr_strobe && (cmd_code == PPFR_CMD_REMAP) && remap_ok) begin
            channel_remap <= cmd_wdata;
        end
    end

    // read answer one cycle after the command
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data <= PPFR_UNMAPPED_READ;
        end else if (ce) begin
            rsp_valid <= rd_strobe;
            if (rd_strobe) begin
                case (cmd_code)
                    PPFR_CMD_FAULT_RO: rsp_data <= stored_status;
                    PPFR_CMD_FAULT_COR: rsp_data <= stored_status;
                    PPFR_CMD_REMAP: rsp_data <= channel_remap;
                    default: rsp_data <= PPFR_UNMAPPED_READ; // unknown code reads zero
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || por);

    logic quiet; // no channel event this cycle
    assign quiet = !(|channel_power_up_command) && !(|channel_turned_off);

    // re-map write that every group rule allows
    sequence s_remap_accept;
        wr_strobe && cmd_code == PPFR_CMD_REMAP && (&channel_is_off) && !remap_dup;
    endsequence

    // re-map write with a channel up or a repeated code
    sequence s_remap_refuse;
        wr_strobe && cmd_code == PPFR_CMD_REMAP && (!(&channel_is_off) || remap_dup);
    endsequence

    // clear-on-read with no channel event to disturb the cells
    sequence s_cor_quiet;
        clear_on_read && quiet;
    endsequence

    // answer of a clear-on-read: old byte out, cells already empty
    sequence s_cor_answer;
        rsp_valid && rsp_data == $past(stored_status) && stored_status == {PPFR_NUM_CH{PPFR_CAUSE_NONE}};
    endsequence

    // 24h answers the stored byte and leaves the cells alone
    property p_ro_read;
        rd_strobe && cmd_code == PPFR_CMD_FAULT_RO && quiet
            |=> rsp_valid && rsp_data == $past(stored_status) && stored_status == $past(stored_status);
    endproperty
    a_ro_read: assert property (p_ro_read) else $error("24h read altered or misreported status");

    // 25h answers first, then leaves zero behind
    property p_cor_read;
        s_cor_quiet |=> s_cor_answer;
    endproperty
    a_cor_read: assert property (p_cor_read) else $error("25h read did not return then clear");

    // channel one keeps the engine's cause when neither masked nor denied
    property p_record;
        ce && channel_power_up_command[0] && !classification_enable_bit[0] && !power_denied[0]
            |=> stored_status[1:0] == $past(fault_cause_in[1:0]);
    endproperty
    a_record: assert property (p_record) else $error("failed turn-on cause not stored");

    // unmasked power denial on channel two stores the top code
    property p_no_power;
        ce && channel_power_up_command[1] && !classification_enable_bit[1] && power_denied[1]
            |=> stored_status[3:2] == PPFR_CAUSE_NO_POWER;
    endproperty
    a_no_power: assert property (p_no_power) else $error("power denial not reported as 11");

    // a masked failure on channel four leaves its field as it was
    property p_class_mask;
        ce && channel_power_up_command[3] && classification_enable_bit[3] && !channel_turned_off[3]
            && !clear_on_read && !soft_reset |=> $stable(stored_status[7:6]);
    endproperty
    a_class_mask: assert property (p_class_mask) else $error("masked failure was recorded");

    // turn-off of channel three with no new failure empties its field
    property p_off_clear;
        ce && channel_turned_off[2] && !channel_power_up_command[2] |=> stored_status[5:4] == PPFR_CAUSE_NONE;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("turn-off did not clear cause");

    // status pins trail the cells by exactly one enabled cycle
    property p_status_mirror;
        ce |=> fault_status == $past(stored_status);
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status pins do not follow the cells");

    // an answer only follows an accepted read and lasts one cycle
    property p_rsp_pulse;
        ce && !rd_strobe |=> !rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("read answer without a read");

    // an allowed re-map write lands on the next edge
    property p_remap_take;
        s_remap_accept |=> channel_remap == $past(cmd_wdata);
    endproperty
    a_remap_take: assert property (p_remap_take) else $error("valid re-map write not stored");

    // a refused re-map write changes nothing
    property p_remap_ignore;
        s_remap_refuse |=> $stable(channel_remap);
    endproperty
    a_remap_ignore: assert property (p_remap_ignore) else $error("re-map write taken when refused");

    // 26h read returns the register as it stood
    property p_remap_read;
        rd_strobe && cmd_code == PPFR_CMD_REMAP |=> rsp_data == $past(channel_remap);
    endproperty
    a_remap_read: assert property (p_remap_read) else $error("re-map read wrong");

    // power-on always restores the identity map, whatever else is going on
    property p_por_default;
        @(posedge clk) disable iff (1'b0) por |=> channel_remap == PPFR_REMAP_DEFAULT;
    endproperty
    a_por_default: assert property (p_por_default) else $error("power-on did not load e4h");

    // pin and software reset never touch the map; only a re-map write may
    property p_pin_keep;
        @(posedge clk) disable iff (por) (rst || soft_reset) && !(wr_strobe && cmd_code == PPFR_CMD_REMAP)
            |=> $stable(channel_remap);
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("re-map lost on pin or soft reset");
endmodule : ppfr_top

//--- verif/ppfr_host_model.sv
// host controller model that issues command-coded byte accesses
module ppfr_host_model (
    // clock
    input wire logic clk,
    // command port toward the registers
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata,
    // read answer
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle port at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
    end
    // one byte access; a read with no answer returns unknown so it cannot match
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wd, output logic [7:0] rd);
        @(negedge clk);
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, wr, code, wd};
        @(negedge clk);
        // released fields show a changed pattern, not the old value
        {cmd_valid, cmd_code, cmd_wdata} = {1'b0, ~code, ~wd};
        rd = (rsp_valid === 1'b1) ? rsp_data : 8'hxx;
    endtask : xfer
endmodule : ppfr_host_model

//--- verif/test_pse_poweron_fault_and_remap.sv
// self-checking bench for the fault status and re-map registers
module test_pse_poweron_fault_and_remap;
    timeunit 1ns;
    timeprecision 1ps;
    import ppfr_pkg::*;
    logic clk, rst, por, ce, cmd_valid, cmd_write, rsp_valid;
    logic [7:0] cmd_code, cmd_wdata, rsp_data, channel_remap, fault_status, fault_cause_in, rd;
    logic [3:0] pwr_cmd, cls_en, power_denied, turned_off, is_off;
    int n_mismatch = 0;
    int samples_checked = 0;
    // table row: write flag, code, write data, expected read
    typedef struct packed {logic wr; logic [7:0] code; logic [7:0] wd; logic [7:0] exp;} ppfr_row_t;
    ppfr_row_t rows [11] = '{{1'b0, 8'h24, 8'h00, 8'h2d}, {1'b0, 8'h25, 8'h00, 8'h2d}, {1'b0, 8'h24, 8'h00, 8'h00},
        {1'b0, 8'h25, 8'h00, 8'h00}, {1'b1, 8'h26, 8'h1b, 8'h00}, {1'b0, 8'h26, 8'h00, 8'h1b},
        {1'b1, 8'h26, 8'h00, 8'h00}, {1'b0, 8'h26, 8'h00, 8'h1b}, {1'b1, 8'h24, 8'hff, 8'h00},
        {1'b0, 8'h24, 8'h00, 8'h00}, {1'b0, 8'h30, 8'h00, 8'h00}};
    ppfr_top ppfr_top_inst (.clk(clk), .rst(rst), .por(por), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .channel_power_up_command(pwr_cmd), .fault_cause_in(fault_cause_in),
        .classification_enable_bit(cls_en), .power_denied(power_denied), .channel_turned_off(turned_off),
        .channel_is_off(is_off), .channel_remap(channel_remap), .fault_status(fault_status));
    ppfr_host_model ppfr_host_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    // compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one-cycle channel event pulse, applied at a falling edge
    task automatic ev(input logic [3:0] c, input logic [7:0] cause, input logic [3:0] cls, input logic [3:0] pd);
        @(negedge clk);
        {pwr_cmd, fault_cause_in, cls_en, power_denied} = {c, cause, cls, pd};
        @(negedge clk);
        pwr_cmd = 4'h0;
    endtask : ev
    // verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // watchdog, well beyond the 65 cycles the tests need
    initial begin
        #20000;
        n_mismatch++;
        results;
    end
    // main sequence
    initial begin
        {rst, por, ce, pwr_cmd, fault_cause_in, cls_en, power_denied, turned_off} = {3'b111, 24'h0};
        is_off = 4'hf;
        repeat (16) @(negedge clk);
        {rst, por} = 2'b00;
        chk("remap", channel_remap, PPFR_REMAP_DEFAULT);
        chk("status", fault_status, PPFR_FAULT_RESET);
        $display("reset test done");
        // ch4 masked by class enable, ch3 class error, ch2 denied power, ch1 detection
        ev(4'hf, 8'h69, 4'h8, 4'h2);
        @(negedge clk);
        chk("status", fault_status, 8'h2d);
        // ordinary accesses, one per row
        foreach (rows[i]) begin
            ppfr_host_model_inst.xfer(rows[i].wr, rows[i].code, rows[i].wd, rd);
            if (!rows[i].wr) chk("read", rd, rows[i].exp);
        end
        $display("table test done");
        // turn-off wipes the stored cause of that channel only
        ev(4'h5, 8'h21, 4'h0, 4'h0);
        ppfr_host_model_inst.xfer(1'b0, PPFR_CMD_FAULT_RO, 8'h00, rd);
        chk("cause", rd, 8'h21);
        @(negedge clk);
        turned_off = 4'h4;
        @(negedge clk);
        turned_off = 4'h0;
        ppfr_host_model_inst.xfer(1'b0, PPFR_CMD_FAULT_RO, 8'h00, rd);
        chk("turnoff", rd, 8'h01);
        // re-map write refused while one channel of the group is up
        is_off = 4'h7;
        ppfr_host_model_inst.xfer(1'b1, PPFR_CMD_REMAP, 8'he4, rd);
        is_off = 4'hf;
        chk("remap busy", channel_remap, 8'h1b);
        // pin reset and soft reset keep the mapping, power-on restores it
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk("remap rst", channel_remap, 8'h1b);
        ppfr_host_model_inst.xfer(1'b0, PPFR_CMD_FAULT_RO, 8'h00, rd);
        chk("status rst", rd, PPFR_FAULT_RESET);
        ev(4'h1, 8'h01, 4'h0, 4'h0);
        ppfr_host_model_inst.xfer(1'b1, PPFR_CMD_SOFT_RESET, 8'h00, rd);
        chk("remap soft", channel_remap, 8'h1b);
        ppfr_host_model_inst.xfer(1'b0, PPFR_CMD_FAULT_RO, 8'h00, rd);
        chk("status soft", rd, PPFR_FAULT_RESET);
        // a low enable freezes the cells, so a failure then is not kept
        ce = 1'b0;
        ev(4'h1, 8'h01, 4'h0, 4'h0);
        ce = 1'b1;
        ppfr_host_model_inst.xfer(1'b0, PPFR_CMD_FAULT_RO, 8'h00, rd);
        chk("frozen", rd, PPFR_FAULT_RESET);
        por = 1'b1;
        @(negedge clk);
        por = 1'b0;
        chk("remap por", channel_remap, PPFR_REMAP_DEFAULT);
        $display("awkward test done");
        results;
    end
endmodule : test_pse_poweron_fault_and_remap
